//--- crp_pkg.sv
package crp_pkg;

  // Word addresses cover byte address bits 35:2
  localparam int unsigned ADDR_W     = 34;
  // Ring pages are 4k bytes, so a page number covers byte address bits 35:12
  localparam int unsigned PAGE_W     = 24;
  localparam int unsigned PAGE_SHIFT = 10;
  localparam int unsigned DEPTH_W    = 24;
  // Snoop window ahead of the write pointer, in words
  localparam int unsigned SNOOP_WIN  = 32;
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 24'h000000;

  // Packet header type codes, bits 2:0
  localparam int unsigned TYPE_LSB  = 0;
  localparam int unsigned TYPE_MSB  = 2;
  localparam logic [2:0] PKT_CTRL   = 3'h0;
  localparam logic [2:0] PKT_REGS   = 3'h1;
  localparam logic [2:0] PKT_MASK2D = 3'h2;

  // Control packet function codes, bits 5:3
  localparam int unsigned FUNC_LSB = 3;
  localparam int unsigned FUNC_MSB = 5;
  localparam logic [2:0] FN_NOP               = 3'h0;
  localparam logic [2:0] FN_CALL              = 3'h1;
  localparam logic [2:0] FN_SUBROUTINE_RETURN = 3'h2;
  localparam logic [2:0] FN_JMP_LOCAL         = 3'h3;
  localparam logic [2:0] FN_JMP_AGP           = 3'h4;

  // Jump target: header bits 28:6 carry address 24:2, second word bits 10:0 carry 35:25
  localparam int unsigned JLO_LSB = 6;
  localparam int unsigned JLO_MSB = 28;
  localparam int unsigned JHI_LSB = 0;
  localparam int unsigned JHI_MSB = 10;

  // Register-write packet fields
  localparam int unsigned CNT_LSB  = 16;
  localparam int unsigned CNT_MSB  = 31;
  localparam int unsigned INC_BIT  = 15;
  localparam int unsigned IS2D_BIT = 14;
  localparam int unsigned CHIP_LSB = 11;
  localparam int unsigned CHIP_MSB = 12;
  localparam int unsigned NUM_LSB  = 3;
  localparam int unsigned NUM_MSB  = 10;

  // Masked 2D packet: mask in bits 31:3, first target is 2D offset 8
  localparam int unsigned MASK_LSB  = 3;
  localparam int unsigned MASK_MSB  = 31;
  localparam int unsigned MASK_W    = 29;
  localparam logic [7:0]  MASK_BASE = 8'h08;

  typedef struct packed {
    logic       is_2d;
    logic [1:0] chip;
    logic [7:0] num;
    logic [31:0] data;
  } crp_reg_wr_s;

  // Step a ring pointer one word, reloading the base when it lands on the rollover address
  function automatic logic [ADDR_W-1:0] crp_step(input logic [ADDR_W-1:0] ptr,
                                                 input logic [ADDR_W-1:0] base,
                                                 input logic [ADDR_W-1:0] roll);
    logic [ADDR_W-1:0] inc;
    inc = ptr + 34'h000000001;
    crp_step = (inc == roll) ? base : inc;
  endfunction

endpackage

//--- crp_mask_walker.sv
`timescale 1ns/1ns
module crp_mask_walker (
  input  wire logic [crp_pkg::MASK_W-1:0] mask,
  output logic      [4:0]                 idx,
  output logic      [crp_pkg::MASK_W-1:0] rest
);

  // Lowest set bit first, so writes come out in ascending order
  always_comb begin
    idx = 5'h00;
    for (int i = crp_pkg::MASK_W - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 5'(i);
      end
    end
  end

  // Clearing the lowest set bit leaves the words still owed
  assign rest = mask & (mask - 29'h00000001);

endmodule

//--- crp_hole_tracker.sv
`timescale 1ns/1ns
module crp_hole_tracker (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       enable,
  input  wire logic                       restart,
  input  wire logic [crp_pkg::ADDR_W-1:0] base_addr,
  input  wire logic [crp_pkg::ADDR_W-1:0] roll_addr,
  input  wire logic                       snoop_valid,
  input  wire logic [crp_pkg::ADDR_W-1:0] snoop_addr,
  output logic      [crp_pkg::ADDR_W-1:0] wptr,
  output logic                            advance
);

  logic [crp_pkg::SNOOP_WIN-1:0] seen;
  logic [crp_pkg::SNOOP_WIN-1:0] mark;
  logic [crp_pkg::SNOOP_WIN-1:0] next_seen;
  logic [crp_pkg::ADDR_W-1:0]    offset;

  // Writes beyond the window are lost; the host never runs that far ahead of the gap
  assign offset = snoop_addr - wptr;

  // Mark each written word, then slide the window by one when its front word is filled
  generate
    for (genvar i = 0; i < crp_pkg::SNOOP_WIN; i++) begin : g_slot
      assign mark[i] = seen[i] | (snoop_valid && offset == 34'(i));
      if (i < crp_pkg::SNOOP_WIN - 1) begin : g_mid
        assign next_seen[i] = seen[0] ? mark[i+1] : mark[i];
      end else begin : g_top
        assign next_seen[i] = seen[0] ? 1'b0 : mark[i];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      seen    <= '0;
      wptr    <= '0;
      advance <= 1'b0;
    end else if (restart || !enable) begin
      seen    <= '0;
      wptr    <= base_addr;
      advance <= 1'b0;
    end else begin
      seen    <= next_seen;
      advance <= seen[0];
      if (seen[0]) begin
        wptr <= crp_pkg::crp_step(wptr, base_addr, roll_addr);
      end
    end
  end

endmodule

//--- crp_command_ring_parser.sv
`timescale 1ns/1ns
module crp_command_ring_parser (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [crp_pkg::PAGE_W-1:0]  ring_base_page,
  input  wire logic [crp_pkg::PAGE_W-1:0]  ring_roll_page,
  input  wire logic                        ring_in_agp,
  input  wire logic                        hw_manage_en,
  input  wire logic                        ring_restart,
  input  wire logic                        bump_valid,
  input  wire logic [crp_pkg::DEPTH_W-1:0] bump_words,
  input  wire logic                        snoop_valid,
  input  wire logic [crp_pkg::ADDR_W-1:0]  snoop_addr,
  output logic                             fetch_req,
  output logic      [crp_pkg::ADDR_W-1:0]  fetch_addr,
  output logic                             fetch_agp,
  input  wire logic                        fetch_ack,
  input  wire logic [31:0]                 fetch_data,
  output logic                             reg_wr_valid,
  output crp_pkg::crp_reg_wr_s             reg_wr,
  output logic                             skipped,
  output logic      [crp_pkg::DEPTH_W-1:0] depth,
  output logic      [crp_pkg::ADDR_W-1:0]  read_ptr,
  output logic      [crp_pkg::ADDR_W-1:0]  write_ptr,
  output logic                             busy
);

  typedef enum logic [1:0] {
    ST_HDR,
    ST_AGP_HI,
    ST_REGS,
    ST_MASK
  } crp_state_e;

  crp_state_e                  state;
  logic                        need_load;
  logic                        src_agp;
  logic [crp_pkg::ADDR_W-1:0]  base_addr;
  logic [crp_pkg::ADDR_W-1:0]  roll_addr;
  logic [crp_pkg::ADDR_W-1:0]  seq_next;
  logic                        hw_mode;
  logic                        hw_advance;
  logic                        take;
  logic [2:0]                  hdr_type;
  logic [2:0]                  hdr_func;
  logic [crp_pkg::ADDR_W-1:0]  ret_ptr;
  logic                        ret_agp;
  logic [22:0]                 jump_lo;
  logic                        jump_now;
  logic                        jump_to_agp;
  logic [crp_pkg::ADDR_W-1:0]  jump_target;
  logic [15:0]                 words_left;
  logic                        dest_inc;
  logic                        dest_2d;
  logic [1:0]                  dest_chip;
  logic [7:0]                  dest_num;
  logic [crp_pkg::MASK_W-1:0]  mask_left;
  logic [4:0]                  mask_idx;
  logic [crp_pkg::MASK_W-1:0]  mask_rest;
  logic [crp_pkg::DEPTH_W-1:0] depth_add;
  logic [crp_pkg::DEPTH_W-1:0] depth_sub;

  // page numbers make the ring a whole number of 4k pages
  assign base_addr = {ring_base_page, 10'h000};
  assign roll_addr = {ring_roll_page, 10'h000};

  // snooping is meaningless for AGP, so an AGP ring falls back to bumps
  assign hw_mode = hw_manage_en && !ring_in_agp;

  // A word is consumed in the cycle the memory answers
  assign take     = fetch_req && fetch_ack;
  assign hdr_type = fetch_data[crp_pkg::TYPE_MSB:crp_pkg::TYPE_LSB];
  assign hdr_func = fetch_data[crp_pkg::FUNC_MSB:crp_pkg::FUNC_LSB];
  assign seq_next = crp_pkg::crp_step(read_ptr, base_addr, roll_addr);

  crp_hole_tracker u_tracker (
    .clk         (clk),
    .rstn        (rstn),
    .enable      (hw_mode),
    .restart     (ring_restart || need_load),
    .base_addr   (base_addr),
    .roll_addr   (roll_addr),
    .snoop_valid (snoop_valid),
    .snoop_addr  (snoop_addr),
    .wptr        (write_ptr),
    .advance     (hw_advance)
  );

  crp_mask_walker u_walker (
    .mask (mask_left),
    .idx  (mask_idx),
    .rest (mask_rest)
  );

  // Reset cannot load a port value, so the base is taken one cycle after release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      need_load <= 1'b1;
    end else begin
      need_load <= 1'b0;
    end
  end

  // Jump decode: header functions and the second word of an AGP jump
  always_comb begin
    jump_now    = 1'b0;
    jump_to_agp = 1'b0;
    jump_target = '0;
    if (take) begin
      unique case (state)
        ST_HDR: begin
          if (hdr_type == crp_pkg::PKT_CTRL) begin
            if (hdr_func == crp_pkg::FN_CALL || hdr_func == crp_pkg::FN_JMP_LOCAL) begin
              jump_now    = 1'b1;
              jump_target = 34'(fetch_data[crp_pkg::JLO_MSB:crp_pkg::JLO_LSB]);
            end else if (hdr_func == crp_pkg::FN_SUBROUTINE_RETURN) begin
              jump_now    = 1'b1;
              jump_target = ret_ptr;
              jump_to_agp = ret_agp;
            end
          end
        end
        ST_AGP_HI: begin
          jump_now    = 1'b1;
          jump_to_agp = 1'b1;
          jump_target = {fetch_data[crp_pkg::JHI_MSB:crp_pkg::JHI_LSB], jump_lo};
        end
        ST_REGS, ST_MASK: begin
          jump_now = 1'b0;
        end
      endcase
    end
  end

  // read pointer walks the ring, reloading base at rollover
  always_ff @(posedge clk) begin
    if (!rstn) begin
      read_ptr <= '0;
      src_agp  <= 1'b0;
    end else if (need_load || ring_restart) begin
      read_ptr <= base_addr;
      src_agp  <= ring_in_agp;
    end else if (jump_now) begin
      read_ptr <= jump_target;
      src_agp  <= jump_to_agp;
    end else if (take) begin
      read_ptr <= seq_next;
    end
  end

  // a single return slot; a second call overwrites it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ret_ptr <= '0;
      ret_agp <= 1'b0;
    end else if (take && state == ST_HDR && hdr_type == crp_pkg::PKT_CTRL &&
                 hdr_func == crp_pkg::FN_CALL) begin
      ret_ptr <= seq_next;
      ret_agp <= src_agp;
    end
  end

  // Pending words: bumps or snooped runs in, fetched words out
  always_comb begin
    depth_add = '0;
    if (hw_mode) begin
      depth_add = {23'h000000, hw_advance};
    end else if (bump_valid) begin
      depth_add = bump_words;
    end
    depth_sub = {23'h000000, take};
  end

  always_ff @(posedge clk) begin
    if (!rstn || ring_restart) begin
      depth <= crp_pkg::DEPTH_RST;
    end else begin
      depth <= depth + depth_add - depth_sub;
    end
  end

  // request a word whenever depth is nonzero; one outstanding at a time
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fetch_req  <= 1'b0;
      fetch_addr <= '0;
      fetch_agp  <= 1'b0;
    end else if (ring_restart || take) begin
      fetch_req <= 1'b0;
    end else if (!fetch_req && !need_load && depth != '0) begin
      fetch_req  <= 1'b1;
      fetch_addr <= read_ptr;
      fetch_agp  <= src_agp;
    end
  end

  // Packet parser: header decode and data word sequencing
  always_ff @(posedge clk) begin
    if (!rstn || ring_restart) begin
      state      <= ST_HDR;
      jump_lo    <= '0;
      words_left <= '0;
      mask_left  <= '0;
    end else if (take) begin
      unique case (state)
        ST_HDR: begin
          unique case (hdr_type)
            crp_pkg::PKT_CTRL: begin
              if (hdr_func == crp_pkg::FN_JMP_AGP) begin
                jump_lo <= fetch_data[crp_pkg::JLO_MSB:crp_pkg::JLO_LSB];
                state   <= ST_AGP_HI;
              end
            end
            crp_pkg::PKT_REGS: begin
              if (fetch_data[crp_pkg::CNT_MSB:crp_pkg::CNT_LSB] != 16'h0000) begin
                words_left <= fetch_data[crp_pkg::CNT_MSB:crp_pkg::CNT_LSB];
                state      <= ST_REGS;
              end
            end
            crp_pkg::PKT_MASK2D: begin
              // zero mask is a lone header
              if (fetch_data[crp_pkg::MASK_MSB:crp_pkg::MASK_LSB] != '0) begin
                mask_left <= fetch_data[crp_pkg::MASK_MSB:crp_pkg::MASK_LSB];
                state     <= ST_MASK;
              end
            end
            default: begin
              state <= ST_HDR;
            end
          endcase
        end
        ST_AGP_HI: begin
          state <= ST_HDR;
        end
        ST_REGS: begin
          words_left <= words_left - 16'h0001;
          if (words_left == 16'h0001) begin
            state <= ST_HDR;
          end
        end
        ST_MASK: begin
          mask_left <= mask_rest;
          if (mask_rest == '0) begin
            state <= ST_HDR;
          end
        end
      endcase
    end
  end

  // destination decode for register packets; number steps in increment mode
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dest_inc  <= 1'b0;
      dest_2d   <= 1'b0;
      dest_chip <= '0;
      dest_num  <= '0;
    end else if (take && state == ST_HDR && hdr_type == crp_pkg::PKT_REGS) begin
      dest_inc  <= fetch_data[crp_pkg::INC_BIT];
      dest_2d   <= fetch_data[crp_pkg::IS2D_BIT];
      dest_chip <= fetch_data[crp_pkg::CHIP_MSB:crp_pkg::CHIP_LSB];
      dest_num  <= fetch_data[crp_pkg::NUM_MSB:crp_pkg::NUM_LSB];
    end else if (take && state == ST_REGS && dest_inc) begin
      dest_num <= dest_num + 8'h01;
    end
  end

  // Register write strobe, one cycle per data word; no back-pressure from targets
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_wr_valid <= 1'b0;
      reg_wr       <= '0;
    end else begin
      reg_wr_valid <= take && (state == ST_REGS || state == ST_MASK);
      if (take && state == ST_REGS) begin
        reg_wr.is_2d <= dest_2d;
        reg_wr.chip  <= dest_chip;
        reg_wr.num   <= dest_num;
        reg_wr.data  <= fetch_data;
      end else if (take && state == ST_MASK) begin
        reg_wr.is_2d <= 1'b1;
        reg_wr.chip  <= 2'h0;
        reg_wr.num   <= crp_pkg::MASK_BASE + {3'h0, mask_idx};
        reg_wr.data  <= fetch_data;
      end
    end
  end

  // reserved codes flagged and dropped as a single word
  always_ff @(posedge clk) begin
    if (!rstn) begin
      skipped <= 1'b0;
    end else begin
      skipped <= take && state == ST_HDR &&
                 ((hdr_type == crp_pkg::PKT_CTRL && hdr_func > crp_pkg::FN_JMP_AGP) ||
                  (hdr_type != crp_pkg::PKT_CTRL && hdr_type != crp_pkg::PKT_REGS &&
                   hdr_type != crp_pkg::PKT_MASK2D));
    end
  end

  // Busy while words are pending, a fetch is out, or a packet is half parsed
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy <= 1'b0;
    end else begin
      busy <= (depth != '0) || fetch_req || (state != ST_HDR);
    end
  end

endmodule

//--- crp_command_ring_parser_monitor.sv
`timescale 1ns/1ns
module crp_command_ring_parser_monitor (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [crp_pkg::PAGE_W-1:0]  ring_base_page,
  input  wire logic                        ring_in_agp,
  input  wire logic                        hw_manage_en,
  input  wire logic                        ring_restart,
  input  wire logic                        bump_valid,
  input  wire logic [crp_pkg::DEPTH_W-1:0] bump_words,
  input  wire logic                        fetch_req,
  input  wire logic [crp_pkg::ADDR_W-1:0]  fetch_addr,
  input  wire logic                        fetch_ack,
  input  wire logic [31:0]                 fetch_data,
  input  wire logic                        reg_wr_valid,
  input  wire crp_pkg::crp_reg_wr_s        reg_wr,
  input  wire logic                        skipped,
  input  wire logic [crp_pkg::DEPTH_W-1:0] depth,
  input  wire logic [crp_pkg::ADDR_W-1:0]  read_ptr
);
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic        sw_mode;
  logic        last_take;
  logic [31:0] last_data;
  // Software depth keeping rules unless the ring is local and snooping is asked for
  assign sw_mode = ring_in_agp || !hw_manage_en;

  // Word taken at the previous edge, so outputs can be tied to their cause
  always_ff @(posedge clk) begin
    if (!rstn) begin
      last_take <= 1'b0;
    end else begin
      last_take <= fetch_req && fetch_ack;
    end
  end
  always_ff @(posedge clk) begin
    last_data <= fetch_data;
  end

  // Consumed word, then the parser asking again
  sequence s_consume;
    fetch_req && fetch_ack;
  endsequence
  sequence s_resume;
    ##[1:4] fetch_req;
  endsequence

  a_fetch_hold: assert property (fetch_req && !fetch_ack && !ring_restart |=> fetch_req && $stable(fetch_addr))
    else $error("fetch request changed before ack");
  a_depth_dec: assert property (s_consume ##0 (sw_mode && !bump_valid && !ring_restart) |=>
    depth == $past(depth) - 24'h000001) else $error("depth not lowered by a fetched word");
  a_bump_add: assert property (bump_valid && sw_mode && !ring_restart && !(fetch_req && fetch_ack) |=>
    depth == $past(depth) + $past(bump_words)) else $error("bump not added to depth");
  a_stall_zero: assert property (depth == 24'h000000 && !fetch_req |=> !fetch_req)
    else $error("fetch started with zero depth");
  a_keep_fetch: assert property (depth != 24'h000000 && !fetch_req && !ring_restart |-> s_resume)
    else $error("parser idle with pending depth");
  a_wr_source: assert property (reg_wr_valid |-> last_take && reg_wr.data == last_data)
    else $error("register write without its fetched word");
  a_skip_cause: assert property (skipped |-> last_take &&
    (last_data[2:0] > 3'h2 || (last_data[2:0] == 3'h0 && last_data[5:3] > 3'h4))) else $error("bad skip");
  a_restart_base: assert property (ring_restart |=> depth == 24'h000000 && !fetch_req &&
    read_ptr == {ring_base_page, 10'h000}) else $error("restart did not reload the ring");
  a_agp_sw: assert property (ring_in_agp && !bump_valid && !(fetch_req && fetch_ack) && !ring_restart |=>
    depth == $past(depth)) else $error("depth moved without bump or fetch");
endmodule

//--- crp_host_mem.sv
`timescale 1ns/1ns
module crp_host_mem (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       fetch_req,
  input  wire logic [crp_pkg::ADDR_W-1:0] fetch_addr,
  output logic                            fetch_ack,
  output logic      [31:0]                fetch_data
);
  logic [31:0] mem [0:4095];
  int          delay;
  int          wait_cnt;

  // Memory starts as no-op headers; low address bits only, so keep images apart
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 32'h00000000;
    end
    delay = 0;
    wait_cnt = 0;
    fetch_ack = 1'b0;
    fetch_data = 32'h5a5a5a5a;
  end

  // Answer after delay cycles; outside the ack cycle the data bus keeps toggling
  always @(posedge clk) begin
    if (!rstn) begin
      fetch_ack <= 1'b0;
      wait_cnt <= 0;
    end else if (fetch_ack) begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      wait_cnt <= 0;
    end else if (fetch_req && wait_cnt >= delay) begin
      fetch_ack <= 1'b1;
      fetch_data <= mem[fetch_addr[11:0]];
    end else begin
      fetch_data <= ~fetch_data;
      wait_cnt <= fetch_req ? wait_cnt + 1 : 0;
    end
  end
endmodule

//--- crp_tb.sv
`timescale 1ns/1ns
module tb;
  localparam logic [33:0] BASE = 34'h000000400;
  logic                        clk;
  logic                        rstn;
  logic [crp_pkg::PAGE_W-1:0]  ring_base_page;
  logic [crp_pkg::PAGE_W-1:0]  ring_roll_page;
  logic                        ring_in_agp;
  logic                        hw_manage_en;
  logic                        ring_restart;
  logic                        bump_valid;
  logic [crp_pkg::DEPTH_W-1:0] bump_words;
  logic                        snoop_valid;
  logic [crp_pkg::ADDR_W-1:0]  snoop_addr;
  logic                        fetch_req;
  logic [crp_pkg::ADDR_W-1:0]  fetch_addr;
  logic                        fetch_agp;
  logic                        fetch_ack;
  logic [31:0]                 fetch_data;
  logic                        reg_wr_valid;
  crp_pkg::crp_reg_wr_s        reg_wr;
  logic                        skipped;
  logic [crp_pkg::DEPTH_W-1:0] depth;
  logic [crp_pkg::ADDR_W-1:0]  read_ptr;
  logic [crp_pkg::ADDR_W-1:0]  write_ptr;
  logic                        busy;
  logic [33:0]                 p;
  logic [33:0]                 agp_addr;
  crp_pkg::crp_reg_wr_s        wr_q[$];
  int                          skip_n;
  int                          err_count;
  int                          total_checks;
  int                          cycles;

  crp_command_ring_parser dut_u (.clk(clk), .rstn(rstn), .ring_base_page(ring_base_page),
    .ring_roll_page(ring_roll_page), .ring_in_agp(ring_in_agp), .hw_manage_en(hw_manage_en),
    .ring_restart(ring_restart), .bump_valid(bump_valid), .bump_words(bump_words), .snoop_valid(snoop_valid),
    .snoop_addr(snoop_addr), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_agp(fetch_agp),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr),
    .skipped(skipped), .depth(depth), .read_ptr(read_ptr), .write_ptr(write_ptr), .busy(busy));
  crp_host_mem mem_u (.clk(clk), .rstn(rstn), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data));

  // Clock, and a hang guard well beyond the longest scenario
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // Log what the parser hands on
  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1) wr_q.push_back(reg_wr);
    if (skipped === 1'b1) skip_n++;
    if (fetch_req === 1'b1 && fetch_ack === 1'b1 && fetch_agp === 1'b1) agp_addr = fetch_addr;
  end

  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  function automatic crp_pkg::crp_reg_wr_s mk(input logic d2, input logic [1:0] ch, input logic [7:0] n,
                                              input logic [31:0] d);
    mk = '{is_2d: d2, chip: ch, num: n, data: d};
  endfunction
  task automatic cmp_log(input crp_pkg::crp_reg_wr_s e[$]);
    check(64'(wr_q.size()), 64'(e.size()));
    foreach (e[i]) check(64'(wr_q[i]), 64'(e[i]));
    wr_q.delete();
  endtask
  // Host side: whole words into the ring image, then the depth news
  task automatic load(input logic [33:0] a, input logic [31:0] w[$]);
    // whole words land before any bump
    foreach (w[i]) mem_u.mem[a[11:0] + 12'(i)] = w[i];
  endtask
  task automatic bump(input logic [23:0] n);
    @(posedge clk);
    bump_valid <= 1'b1;
    bump_words <= n;
    @(posedge clk);
    bump_valid <= 1'b0;
  endtask
  task automatic snoop(input logic [33:0] a);
    @(posedge clk);
    snoop_valid <= 1'b1;
    snoop_addr <= a;
    @(posedge clk);
    snoop_valid <= 1'b0;
  endtask
  task automatic restart(input logic hw);
    @(posedge clk);
    ring_restart <= 1'b1;
    hw_manage_en <= hw;
    ring_in_agp <= 1'b0;
    @(posedge clk);
    ring_restart <= 1'b0;
  endtask
  task automatic run_idle;
    repeat (3) @(negedge clk);
    while (depth !== 24'h000000 || busy !== 1'b0) @(negedge clk);
  endtask

  task automatic t_reset;
    repeat (3) @(negedge clk);
    check(read_ptr, BASE);
    check(depth, 24'h000000);
  endtask
  task automatic t_regs;
    mem_u.delay = 3;
    load(p, '{32'h0003c881, 32'ha0, 32'ha1, 32'ha2, 32'h00020101, 32'hb0, 32'hb1});
    bump(24'h000007);
    run_idle();
    cmp_log('{mk(1, 1, 8'h10, 32'ha0), mk(1, 1, 8'h11, 32'ha1), mk(1, 1, 8'h12, 32'ha2),
              mk(0, 0, 8'h20, 32'hb0), mk(0, 0, 8'h20, 32'hb1)});
    check(read_ptr, p + 34'h7);
    p = p + 34'h7;
  endtask
  // masked packet, header stalls before its data arrives
  task automatic t_mask;
    load(p, '{32'h8000010a, 32'hc0, 32'hc1, 32'hc2});
    bump(24'h000001);
    repeat (12) @(negedge clk);
    check(wr_q.size(), 0);
    check(busy, 1'b1);
    bump(24'h000003);
    run_idle();
    cmp_log('{mk(1, 0, 8'h08, 32'hc0), mk(1, 0, 8'h0d, 32'hc1), mk(1, 0, 8'h24, 32'hc2)});
    check(read_ptr, p + 34'h4);
    p = p + 34'h4;
  endtask
  // reserved codes, call and return, local jumps
  task automatic t_ctrl;
    mem_u.delay = 0;
    skip_n = 0;
    // control headers keep bits 31:29 zero
    load(p, '{32'h00000003, 32'h00000028, 32'h0002ee08, 32'h00030718});
    load(34'h0bb8, '{32'h00010181, 32'hd0, 32'h00000010});
    load(34'h0c1c, '{32'h00010189, 32'hd1, 32'((p + 34'h4) << 6) | 32'h00000018});
    bump(24'h00000a);
    run_idle();
    cmp_log('{mk(0, 0, 8'h30, 32'hd0), mk(0, 0, 8'h31, 32'hd1)});
    check(skip_n, 2);
    check(read_ptr, p + 34'h4);
    p = p + 34'h4;
  endtask
  task automatic t_agp;
    agp_addr = 34'h0;
    load(p, '{32'h00007d20, 32'h00000001});
    load(34'h01f4, '{32'((p + 34'h2) << 6) | 32'h00000018});
    bump(24'h000003);
    run_idle();
    check(agp_addr, 34'h0008001f4);
    check(read_ptr, p + 34'h2);
    // The space flag only moves with the next request, so pull one local word
    load(p + 34'h2, '{32'h00000000});
    bump(24'h000001);
    run_idle();
    check(fetch_agp, 1'b0);
  endtask
  // snooped depth: out-of-order writes, ignored bumps, far ring
  task automatic t_hw;
    restart(1'b1);
    load(BASE, '{32'h0, 32'h0, 32'h0, 32'h0});
    snoop(BASE + 34'h1);
    repeat (4) @(negedge clk);
    check(depth, 24'h000000);
    snoop(BASE);
    run_idle();
    check(write_ptr, BASE + 34'h2);
    check(read_ptr, BASE + 34'h2);
    bump(24'h000005);
    run_idle();
    check(read_ptr, BASE + 34'h2);
    @(posedge clk);
    ring_in_agp <= 1'b1;
    snoop(BASE + 34'h2);
    repeat (4) @(negedge clk);
    check(depth, 24'h000000);
    bump(24'h000001);
    run_idle();
    check(read_ptr, BASE + 34'h3);
  endtask
  // a one-page ring of no-ops rolls back to its base
  task automatic t_roll;
    restart(1'b0);
    for (int i = 0; i < 1024; i++) mem_u.mem[12'h400 + 12'(i)] = 32'h00000000;
    bump(24'h000400);
    run_idle();
    check(read_ptr, BASE);
    check(wr_q.size(), 0);
  endtask

  // Quiet inputs, then reset held for 8 cycles
  initial begin
    rstn = 1'b0;
    ring_base_page = 24'h000001;
    ring_roll_page = 24'h000002;
    ring_in_agp = 1'b0;
    hw_manage_en = 1'b0;
    ring_restart = 1'b0;
    bump_valid = 1'b0;
    bump_words = 24'h000000;
    snoop_valid = 1'b0;
    snoop_addr = 34'h0;
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    skip_n = 0;
    p = BASE;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    t_mask();
    t_ctrl();
    t_agp();
    t_hw();
    t_roll();
    wrap_up();
  end
endmodule

bind crp_command_ring_parser crp_command_ring_parser_monitor mon_u (.clk(clk), .rstn(rstn),
  .ring_base_page(ring_base_page), .ring_in_agp(ring_in_agp), .hw_manage_en(hw_manage_en),
  .ring_restart(ring_restart), .bump_valid(bump_valid), .bump_words(bump_words), .fetch_req(fetch_req),
  .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data), .reg_wr_valid(reg_wr_valid),
  .reg_wr(reg_wr), .skipped(skipped), .depth(depth), .read_ptr(read_ptr));
